/* pll_synth_config_logic.sv */
// configuration, dividers and output gate of the clock synthesizer
`timescale 1ns/1ps
module pll_synth_config_logic (
    input wire logic mclk, // crystal oscillator clock
    input wire logic rst, // synchronous reset, active high
    input wire logic hsel, // ahb slave select
    input wire logic [pll_cfg_pkg::ADDR_W-1:0] haddr, // ahb address
    input wire logic [1:0] htrans, // ahb transfer type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size
    input wire logic [pll_cfg_pkg::DATA_W-1:0] hwdata, // ahb write data
    input wire logic hready, // ahb bus ready
    output logic hreadyout, // ahb slave ready
    output logic [pll_cfg_pkg::DATA_W-1:0] hrdata, // ahb read data
    output logic hresp, // ahb response, always okay
    input wire logic vcoClk, // vco clock from analog loop
    input wire logic [pll_cfg_pkg::M_W-1:0] mIn, // parallel feedback value
    input wire logic [pll_cfg_pkg::N_W-1:0] nIn, // parallel post select
    input wire logic pLoad, // parallel load strobe
    input wire logic sLoad, // serial load strobe
    input wire logic sClock, // serial shift clock
    input wire logic sData, // serial data
    input wire logic oe, // output gate request
    output logic refTickOut, // reference pulse to phase detector
    output logic fbTickOut, // feedback pulse to phase detector
    output logic diffClockOut, // synthesized clock, true leg
    output logic diffClockOutN, // synthesized clock, complement leg
    output logic testOut // diagnostic output
);
    import pll_cfg_pkg::*;

    typedef struct packed {
        logic [PIN_W-1:0] meta;
        logic [PIN_W-1:0] sync;
        logic vcoPrev;
        logic sClockPrev;
        logic [3:0] refCnt;
        logic refTick;
        logic [FB_W-1:0] fbCnt;
        logic fbTick;
        logic [2:0] postCnt;
        logic divOut;
        logic gate;
        logic clkOut;
        logic [M_W-1:0] activeM;
        logic [N_W-1:0] activeN;
        logic [T_W-1:0] activeT;
        logic [SHIFT_LEN-1:0] shiftReg;
        logic testSel;
        logic softOff;
        logic wrPend;
        logic [7:0] wrAddr;
        logic [DATA_W-1:0] rdata;
    } state_type;

    state_type st;
    state_type next_st;

    // last count of the feedback divider for a given M
    function automatic logic [FB_W-1:0] fbLast(input logic [M_W-1:0] m);
        logic [FB_W-1:0] full;
        full = {m, 2'h0};
        return full - 11'h001;
    endfunction

    // word-aligned register offset of a bus address
    function automatic logic [7:0] regOffset(input logic [ADDR_W-1:0] a);
        return {a[7:2], 2'h0};
    endfunction

    logic [PIN_W-1:0] pins;
    logic vcoS;
    logic vcoRise;
    logic sClockRise;
    logic sDataS;
    logic pLoadS;
    logic sLoadS;
    logic oeS;
    logic [M_W-1:0] mSync;
    logic [N_W-1:0] nSync;
    logic addrPhase;
    logic [DATA_W-1:0] statusWord;

    // gather pins into one synchroniser vector
    assign pins = {vcoClk, oe, pLoad, sLoad, sClock, sData, nIn, mIn};
    assign vcoS = st.sync[PIN_VCO];
    assign oeS = st.sync[PIN_OE];
    assign pLoadS = st.sync[PIN_PLOAD];
    assign sLoadS = st.sync[PIN_SLOAD];
    assign sDataS = st.sync[PIN_SDATA];
    assign mSync = st.sync[PIN_M +: M_W];
    assign nSync = st.sync[PIN_N +: N_W];
    assign vcoRise = vcoS & ~st.vcoPrev;
    assign sClockRise = st.sync[PIN_SCLOCK] & ~st.sClockPrev;
    assign addrPhase = hsel & hready & htrans[1];

    // status word shows the live configuration and gate
    always_comb begin
        statusWord = '0;
        statusWord[STAT_M_LSB +: M_W] = st.activeM;
        statusWord[STAT_N_LSB +: N_W] = st.activeN;
        statusWord[STAT_T_LSB +: T_W] = st.activeT;
        statusWord[STAT_GATE] = st.gate;
        statusWord[STAT_PLOAD] = pLoadS;
        statusWord[STAT_SLOAD] = sLoadS;
    end

    // next state of the whole block
    always_comb begin
        next_st = st;
        next_st.meta = pins;
        next_st.sync = st.meta;
        next_st.vcoPrev = vcoS;
        next_st.sClockPrev = st.sync[PIN_SCLOCK];
        // crystal divided by sixteen
        next_st.refTick = 1'b0;
        if (st.refCnt == REF_DIV_LAST) begin
            next_st.refCnt = 4'h0;
            next_st.refTick = 1'b1;
        end else begin
            next_st.refCnt = st.refCnt + 4'h1;
        end
        // feedback divider over four times M vco cycles
        next_st.fbTick = 1'b0;
        if (vcoRise) begin
            if (st.fbCnt >= fbLast(st.activeM)) begin
                next_st.fbCnt = '0;
                next_st.fbTick = 1'b1;
            end else begin
                next_st.fbCnt = st.fbCnt + 11'h001;
            end
            next_st.postCnt = st.postCnt + 3'h1;
        end
        // post-divider, each tap is a square wave
        case (st.activeN)
            POST_DIV1: next_st.divOut = vcoS;
            POST_DIV2: next_st.divOut = st.postCnt[0];
            POST_DIV4: next_st.divOut = st.postCnt[1];
            POST_DIV8: next_st.divOut = st.postCnt[2];
            default: next_st.divOut = vcoS;
        endcase
        // gate may change only while the output clock is low
        if (!st.divOut) begin
            next_st.gate = oeS & ~st.softOff;
        end
        next_st.clkOut = next_st.divOut & next_st.gate;
        // serial shift register
        if (sClockRise) begin
            next_st.shiftReg = {st.shiftReg[SHIFT_LEN-2:0], sDataS};
        end
        // configuration latches, parallel wins
        if (!pLoadS) begin
            next_st.activeM = mSync;
            next_st.activeN = nSync;
        end else if (sLoadS) begin
            next_st.activeM = st.shiftReg[SER_M_LSB +: M_W];
            next_st.activeN = st.shiftReg[SER_N_LSB +: N_W];
            next_st.activeT = st.shiftReg[SER_T_LSB +: T_W];
        end
        // diagnostic output select
        case (st.activeT)
            TEST_QUIET: next_st.testSel = 1'b0;
            TEST_REF: next_st.testSel = st.refCnt[3];
            TEST_FB: next_st.testSel = st.fbTick;
            TEST_VCO: next_st.testSel = vcoS;
            TEST_OUT: next_st.testSel = st.clkOut;
            TEST_HIGH: next_st.testSel = 1'b1;
            default: next_st.testSel = 1'b0;
        endcase
        // bus data phase write
        next_st.wrPend = 1'b0;
        if (st.wrPend && st.wrAddr == REG_CTRL) begin
            next_st.softOff = hwdata[CTRL_SOFTOFF];
        end
        // bus address phase
        if (addrPhase) begin
            next_st.wrPend = hwrite & (hsize == HSIZE_WORD);
            next_st.wrAddr = regOffset(haddr);
            case (regOffset(haddr))
                REG_CTRL: next_st.rdata = {31'h0, st.softOff};
                REG_STATUS: next_st.rdata = statusWord;
                default: next_st.rdata = '0;
            endcase
        end
    end

    // state register, pins reset to their idle levels
    always_ff @(posedge mclk) begin
        if (rst) begin
            st <= '0;
            st.meta <= PIN_DEFAULTS;
            st.sync <= PIN_DEFAULTS;
            st.activeM <= M_DEFAULT;
            st.activeN <= N_DEFAULT;
            st.activeT <= TEST_QUIET;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.rdata;
    assign refTickOut = st.refTick;
    assign fbTickOut = st.fbTick;
    assign diffClockOut = st.clkOut;
    assign diffClockOutN = ~st.clkOut;
    assign testOut = st.testSel;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence parRelease;
        $rose(pLoadS) ##1 (pLoadS && !sLoadS);
    endsequence

    sequence vcoWrap;
        vcoRise && st.fbCnt >= fbLast(st.activeM);
    endsequence

    // reference period of sixteen
    a_ref_period: assert property (
        st.refTick |-> ##16 st.refTick)
        else $error("reference tick period is not sixteen");

    // feedback tick follows the wrap of the divider
    a_fb_wrap: assert property (
        vcoWrap |=> st.fbTick && st.fbCnt == 11'h000)
        else $error("feedback divider did not wrap");

    // divide-by-eight output follows the top counter bit
    a_post_div8: assert property (
        st.activeN == POST_DIV8 && $stable(st.activeN)
        |=> st.divOut == $past(st.postCnt[2]))
        else $error("post divide by eight wrong");

    // latches follow the parallel inputs while strobe is low
    a_par_follow: assert property (
        !pLoadS |=> st.activeM == $past(mSync) && st.activeN == $past(nSync))
        else $error("latches do not follow parallel inputs");

    // parallel value held after strobe rises
    a_par_hold: assert property (
        parRelease |-> $stable(st.activeM) && $stable(st.activeN))
        else $error("parallel value not held after strobe rise");

    // parallel wins over serial
    a_par_priority: assert property (
        !pLoadS && sLoadS |=> st.activeM == $past(mSync))
        else $error("serial load overrode parallel port");

    // serial strobe high makes latches follow shift register
    a_ser_follow: assert property (
        pLoadS && sLoadS |=> st.activeM == $past(st.shiftReg[8:0])
        && st.activeT == $past(st.shiftReg[13:11]))
        else $error("latches do not follow shift register");

    // one bit per serial clock edge
    a_shift_step: assert property (
        sClockRise |=> st.shiftReg == {$past(st.shiftReg[12:0]), $past(sDataS)})
        else $error("shift register did not advance one bit");

    // gate moves only while the divided clock is low
    a_gate_sync: assert property (
        $changed(st.gate) |-> !$past(st.divOut))
        else $error("output gate changed while clock high");

    // stopped output rests true low, complement high
    a_gate_stop: assert property (
        !st.gate |-> !diffClockOut && diffClockOutN)
        else $error("gated output not parked low");

    // quiet test select keeps diagnostic output low
    a_test_quiet: assert property (
        st.activeT == TEST_QUIET && $stable(st.activeT) |=> !testOut)
        else $error("diagnostic output active in quiet setting");

    // divide-by-one output follows the vco
    a_div1_follow: assert property (
        st.activeN == POST_DIV1 && $stable(st.activeN)
        |=> st.divOut == $past(vcoS))
        else $error("post divide by one wrong");

    // divide-by-two output follows the low counter bit
    a_div2_tap: assert property (
        st.activeN == POST_DIV2 && $stable(st.activeN)
        |=> st.divOut == $past(st.postCnt[0]))
        else $error("post divide by two wrong");

    // divide-by-four output follows the middle counter bit
    a_div4_tap: assert property (
        st.activeN == POST_DIV4 && $stable(st.activeN)
        |=> st.divOut == $past(st.postCnt[1]))
        else $error("post divide by four wrong");

    // gate takes request and soft off while the clock is low
    a_gate_follow: assert property (
        !st.divOut |=> st.gate == ($past(oeS) && !$past(st.softOff)))
        else $error("output gate ignored its request");

    // latches hold while neither strobe is transparent
    a_latch_hold: assert property (
        pLoadS && !sLoadS |=> $stable(st.activeM) && $stable(st.activeN)
        && $stable(st.activeT))
        else $error("configuration latches moved while closed");

    // shift register still without a serial clock edge
    a_shift_idle: assert property (
        !sClockRise |=> $stable(st.shiftReg))
        else $error("shift register moved without a clock edge");

    // high test select keeps diagnostic output high
    a_test_high: assert property (
        st.activeT == TEST_HIGH && $stable(st.activeT) |=> testOut)
        else $error("diagnostic output low in high setting");
endmodule

/* pll_cfg_pkg.sv */
// constants, field layouts and register map of the synthesizer config logic
// Notes on behaviour
// - reference tick is the crystal clock divided by sixteen.
// - feedback divider returns one tick per four times M VCO cycles.
// - post-divider divides VCO by 1, 2, 4 or 8, 50 percent duty.
// - post select 00 is /1, 01 is /2, 10 is /4, 11 is /8.
// - parallel port carries nine-bit M and two-bit N.
// - parallel values are captured on rising edge of the parallel strobe.
// - latches follow parallel inputs while strobe low; host holds inputs.
// - parallel strobe acts on level; low keeps latches transparent.
// - parallel configuration wins over serial when both are active.
// - idle pins: M, N, gate, parallel strobe high; serial pins low.
// - serial word is built in a fourteen-bit shift register.
// - shift register advances one bit per serial clock rising edge.
// - latches follow shift register while serial strobe high, hold on fall.
// - three-bit test select picks what the diagnostic output shows.
// - output gate changes only while output clock is low, no runts.
// - gate low stops the true leg low and complement leg high.
package pll_cfg_pkg;
    localparam int M_W = 9;
    localparam int N_W = 2;
    localparam int T_W = 3;
    localparam int SHIFT_LEN = 14;
    localparam int FB_W = 11;
    localparam int PIN_W = 17;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    // division figures
    localparam logic [3:0] REF_DIV_LAST = 4'hF;
    localparam logic [1:0] FB_MULT_SHIFT = 2'h2;
    // serial word layout, first bit shifted ends at the top
    localparam int SER_M_LSB = 0;
    localparam int SER_N_LSB = 9;
    localparam int SER_T_LSB = 11;
    // synchroniser vector layout
    localparam int PIN_M = 0;
    localparam int PIN_N = 9;
    localparam int PIN_SDATA = 11;
    localparam int PIN_SCLOCK = 12;
    localparam int PIN_SLOAD = 13;
    localparam int PIN_PLOAD = 14;
    localparam int PIN_OE = 15;
    localparam int PIN_VCO = 16;
    // idle pin levels, also synchroniser reset values
    localparam logic [16:0] PIN_DEFAULTS = 17'h0C7FF;
    localparam logic [8:0] M_DEFAULT = 9'h1FF;
    localparam logic [1:0] N_DEFAULT = 2'h3;
    // post-divide select codes
    localparam logic [1:0] POST_DIV1 = 2'h0;
    localparam logic [1:0] POST_DIV2 = 2'h1;
    localparam logic [1:0] POST_DIV4 = 2'h2;
    localparam logic [1:0] POST_DIV8 = 2'h3;
    // diagnostic output select codes
    localparam logic [2:0] TEST_QUIET = 3'h0;
    localparam logic [2:0] TEST_REF = 3'h1;
    localparam logic [2:0] TEST_FB = 3'h2;
    localparam logic [2:0] TEST_VCO = 3'h3;
    localparam logic [2:0] TEST_OUT = 3'h4;
    localparam logic [2:0] TEST_HIGH = 3'h5;
    // bus register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam int CTRL_SOFTOFF = 0;
    localparam int STAT_M_LSB = 0;
    localparam int STAT_N_LSB = 9;
    localparam int STAT_T_LSB = 11;
    localparam int STAT_GATE = 16;
    localparam int STAT_PLOAD = 17;
    localparam int STAT_SLOAD = 18;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

/* pll_host_model.sv */
// host side model driving the synthesizer configuration pins
`timescale 1ns/1ps
module pll_host_model (
    input wire logic mclk, // crystal clock
    output logic vcoClk, // vco clock stand-in
    output logic [pll_cfg_pkg::M_W-1:0] mIn, // parallel feedback value
    output logic [pll_cfg_pkg::N_W-1:0] nIn, // parallel post select
    output logic pLoad, // parallel strobe
    output logic sLoad, // serial strobe
    output logic sClock, // serial clock
    output logic sData, // serial data
    output logic oe // gate request
);
    import pll_cfg_pkg::*;
    // idle levels, parallel strobe held low through reset
    initial begin
        mIn = M_DEFAULT;
        nIn = N_DEFAULT;
        sLoad = 1'b0;
        sClock = 1'b0;
        sData = 1'b0;
        oe = 1'b1;
        pLoad = 1'b0;
        vcoClk = 1'b0;
        #7;
        forever #120 vcoClk = ~vcoClk;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // parallel load, inputs held across the rising strobe
    task automatic par(input logic [8:0] m, input logic [1:0] n);
        pLoad <= 1'b0;
        mIn <= m;
        nIn <= n;
        wt(8);
        pLoad <= 1'b1;
        wt(8);
    endtask
    // one word, first bit ends at the top of the shifter
    task automatic ser(input logic [13:0] w);
        for (int i = 13; i >= 0; i--) begin
            sData <= w[i];
            wt(4);
            sClock <= 1'b1;
            wt(4);
            sClock <= 1'b0;
        end
        wt(1);
        sData <= ~w[0];
    endtask
    // serial strobe, shifter left alone around the fall
    task automatic sload(input logic lv);
        sLoad <= lv;
        wt(8);
    endtask
endmodule

/* pll_synth_config_logic_tb.sv */
// self-checking bench for the synthesizer config logic
`timescale 1ns/1ps
module pll_synth_config_logic_tb;
    import pll_cfg_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic hready, hreadyout, hresp, vcoClk, pLoad, sLoad, sClock, sData, oe;
    logic [31:0] hrdata, rd;
    logic [8:0] mIn;
    logic [1:0] nIn;
    logic refTickOut, fbTickOut, diffClockOut, diffClockOutN, testOut;
    int num_errors = 0;
    int samples_checked = 0;
    int p;
    always #20 mclk = ~mclk;
    assign hready = hreadyout;
    pll_synth_config_logic u_dut (.mclk(mclk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .vcoClk(vcoClk), .mIn(mIn),
        .nIn(nIn), .pLoad(pLoad), .sLoad(sLoad), .sClock(sClock),
        .sData(sData), .oe(oe), .refTickOut(refTickOut),
        .fbTickOut(fbTickOut), .diffClockOut(diffClockOut),
        .diffClockOutN(diffClockOutN), .testOut(testOut));
    pll_host_model u_host (.mclk(mclk), .vcoClk(vcoClk), .mIn(mIn),
        .nIn(nIn), .pLoad(pLoad), .sLoad(sLoad), .sClock(sClock),
        .sData(sData), .oe(oe));
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one single ahb transfer, waits on ready in both phases
    task automatic ahb(input logic wr, input logic [31:0] a, wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask
    task automatic stat(input logic [31:0] e);
        ahb(1'b0, {24'h0, REG_STATUS}, 32'h0);
        chk("status", rd & 32'h00003FFF, e);
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: pick = refTickOut;
            1: pick = fbTickOut;
            2: pick = diffClockOut;
            default: pick = testOut;
        endcase
    endfunction
    // cycles between two rising edges of the picked output
    task automatic per(input int s, output int n);
        int k, r;
        logic q;
        n = 0;
        r = 0;
        q = 1'b1;
        for (k = 0; k < 3000 && r < 2; k++) begin
            @(posedge mclk);
            if (r == 1) n++;
            if (pick(s) === 1'b1 && q === 1'b0) r++;
            q = pick(s);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // serial word shifted in, then latched by a strobe pulse
    task automatic sword(input logic [13:0] w);
        u_host.ser(w);
        u_host.sload(1'b1);
        u_host.sload(1'b0);
    endtask
    // watchdog against a hang
    initial begin
        #1000000;
        num_errors++;
        report_and_stop();
    end
    // test sequence
    initial begin
        wt(8);
        rst <= 1'b0;
        wt(6);
        stat({3'h0, N_DEFAULT, M_DEFAULT});
        chk("hresp", hresp, 32'h0);
        chk("hready", hreadyout, 32'h1);
        $display("test reset done");
        u_host.par(9'h0A5, POST_DIV2);
        stat({3'h0, POST_DIV2, 9'h0A5});
        u_host.mIn <= 9'h011;
        wt(10);
        stat({3'h0, POST_DIV2, 9'h0A5});
        u_host.pLoad <= 1'b0;
        wt(10);
        stat({3'h0, POST_DIV2, 9'h011});
        u_host.ser({TEST_REF, POST_DIV4, 9'h033});
        u_host.sload(1'b1);
        stat({3'h0, POST_DIV2, 9'h011});
        u_host.pLoad <= 1'b1;
        wt(10);
        stat({TEST_REF, POST_DIV4, 9'h033});
        per(3, p);
        chk("test ref", p, 16);
        per(0, p);
        chk("ref tick", p, 16);
        $display("test load paths done");
        u_host.sload(1'b0);
        u_host.ser({TEST_HIGH, POST_DIV1, 9'h002});
        stat({TEST_REF, POST_DIV4, 9'h033});
        u_host.sload(1'b1);
        u_host.sload(1'b0);
        stat({TEST_HIGH, POST_DIV1, 9'h002});
        chk("test high", testOut, 32'h1);
        per(1, p);
        chk("fb tick", p, 48);
        // post divide codes with a vco of six crystal periods
        for (int n = 0; n < 4; n++) begin
            u_host.par(9'h002, n[1:0]);
            per(2, p);
            chk("post div", p, 6 << n);
            chk("compl", diffClockOutN, {31'h0, ~diffClockOut});
        end
        $display("test dividers done");
        u_host.oe <= 1'b0;
        wt(40);
        chk("gate true", diffClockOut, 32'h0);
        chk("gate comp", diffClockOutN, 32'h1);
        u_host.oe <= 1'b1;
        per(2, p);
        chk("gate on", p, 48);
        ahb(1'b1, {24'h0, REG_CTRL}, 32'h1);
        ahb(1'b0, {24'h0, REG_CTRL}, 32'h0);
        chk("ctrl", rd, 32'h1);
        wt(40);
        chk("soft off", diffClockOut, 32'h0);
        ahb(1'b0, {24'h0, REG_STATUS}, 32'h0);
        chk("gate bit", rd[STAT_GATE], 32'h0);
        ahb(1'b1, {24'h0, REG_CTRL}, 32'h0);
        ahb(1'b0, 32'h00000010, 32'h0);
        chk("unmapped", rd, 32'h0);
        $display("test gate done");
        // remaining diagnostic selects, quiet one last
        sword({TEST_VCO, POST_DIV2, 9'h002});
        per(3, p);
        chk("test vco", p, 6);
        sword({TEST_FB, POST_DIV2, 9'h002});
        per(3, p);
        chk("test fb", p, 48);
        sword({TEST_OUT, POST_DIV2, 9'h002});
        per(3, p);
        chk("test out", p, 12);
        sword({TEST_QUIET, POST_DIV2, 9'h002});
        wt(4);
        chk("test quiet", testOut, 32'h0);
        $display("test diagnostics done");
        report_and_stop();
    end
endmodule
